// File: shared/tss_pkg.sv
// tempo sync clock select: register map, field codes and timing constants
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus
package tss_pkg;
  // register byte addresses
  localparam logic [7:0] TSS_REG_CTRL   = 8'h00;
  localparam logic [7:0] TSS_REG_TEMPO  = 8'h04;
  localparam logic [7:0] TSS_REG_STATUS = 8'h08;
  localparam logic [7:0] TSS_REG_POS    = 8'h0C;
  // control field positions
  localparam int TSS_CTRL_IN_SPAN  = 0;
  localparam int TSS_CTRL_OUT_SPAN = 1;
  localparam int TSS_CTRL_IN_FALL  = 2;
  localparam int TSS_CTRL_OUT_FALL = 3;
  localparam int TSS_CTRL_SRC_LO   = 4;
  localparam int TSS_CTRL_RES_LO   = 8;
  localparam int TSS_CTRL_CHAN_LO  = 12;
  localparam int TSS_CTRL_XPORT    = 16;
  localparam int TSS_CTRL_RUN      = 17;
  // reset values and tempo limits
  localparam logic [31:0] TSS_CTRL_RST  = 32'h0001_0020;
  localparam logic [12:0] TSS_TEMPO_RST = 13'h04B0;
  localparam logic [12:0] TSS_TEMPO_MIN = 13'h0064;
  localparam logic [12:0] TSS_TEMPO_MAX = 13'h1770;
  // tempo origin codes
  localparam logic [1:0] TSS_SRC_FOLLOW_USB    = 2'h0;
  localparam logic [1:0] TSS_SRC_FOLLOW_DIN    = 2'h1;
  localparam logic [1:0] TSS_SRC_INTERNAL      = 2'h2;
  // step resolution codes: 1/16, 1/8, 1/4, 1/2, 1/1
  localparam logic [2:0] TSS_RES_16 = 3'h0;
  localparam logic [2:0] TSS_RES_1  = 3'h4;
  // internal tempo: 16th ticks per minute = tempo*4, which is bpm*40; bpm held in tenths
  localparam int          TSS_CLK_HZ     = 50_000_000;
  localparam logic [31:0] TSS_PHASE_FULL = 32'(TSS_CLK_HZ * 15);
  // external clock presence timeout, in ms
  localparam int TSS_LOSS_MS     = 500;
  localparam int TSS_LOSS_CYCLES = TSS_LOSS_MS * (TSS_CLK_HZ / 1000);
  // output pulse width
  localparam int          TSS_PULSE_US     = 5_000;
  localparam logic [23:0] TSS_PULSE_CYCLES = 24'(TSS_PULSE_US * (TSS_CLK_HZ / 1_000_000));
  // midi clock: 24 per quarter, 6 per 16th
  localparam logic [2:0] TSS_MIDI_PER_16 = 3'h6;
  // real-time message codes
  localparam logic [7:0] TSS_RT_CLOCK = 8'hF8;
  localparam logic [7:0] TSS_RT_START = 8'hFA;
  localparam logic [7:0] TSS_RT_CONT  = 8'hFB;
  localparam logic [7:0] TSS_RT_STOP  = 8'hFC;
endpackage

// File: verilog/tss_tempo_sync.sv
// tempo sync clock select: source choice, pulse in/out, transport gate
// assumes midi bytes arrive on link_clock as strobed bytes, usb bytes on clock
//
// Behaviour
// - input span sixteenth: each valid input pulse advances one sixteenth
// - input span eighth: each valid input pulse advances one eighth
// - output span sixteenth: one output pulse per sixteenth progressed; with input span eighth the two pulses merge into one
// - output span eighth: one output pulse per eighth progressed
// - at 1/16 resolution a sixteenth is one step, an eighth two
// - input edge choice picks rising or falling edge as sync event
// - output edge choice makes the sync event rising or falling
// - one channel 1..16 both sends and accepts; remote must match
// - automatic sources run internal until that port's clock is detected
// - internal origin ignores usb and midi clock messages
// - connected pulse jack overrides the tempo origin setting
// - start, stop, continue acted on only when transport gate is on
// - step duration from resolution 1/16, 1/8, 1/4, 1/2, 1/1
// - internal tempo 10.0 to 600.0 bpm in tenth steps
`timescale 1ns/1ps
module tss_tempo_sync
  import tss_pkg::*;
#(
  parameter int LOSS_CYCLES  = TSS_LOSS_CYCLES,
  parameter int PULSE_CYCLES = int'(TSS_PULSE_CYCLES)
) (
  // system
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // midi din link domain
  input  wire logic        link_clock,
  input  wire logic        link_rst,
  input  wire logic        din_byte_valid,
  input  wire logic [7:0]  din_byte,
  // usb midi bytes, system domain
  input  wire logic        usb_byte_valid,
  input  wire logic [7:0]  usb_byte,
  // jacks
  input  wire logic        pulse_in,
  input  wire logic        pulse_in_present,
  output logic             pulse_out,
  // sequencer side
  output logic             step_advance,
  output logic             seq_running,
  output logic [3:0]       link_channel_number,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [1:0] {
    TSS_ORG_INT  = 2'b00,
    TSS_ORG_USB  = 2'b01,
    TSS_ORG_DIN  = 2'b10,
    TSS_ORG_JACK = 2'b11
  } tss_org_e;

  logic [31:0] ctrl;
  logic [12:0] tempo;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // ===========================================================
  // axi4-lite write channel
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_hold && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == TSS_REG_CTRL || aw_addr == TSS_REG_TEMPO) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and tempo registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl  <= TSS_CTRL_RST;
      tempo <= TSS_TEMPO_RST;
    end else if (wr_go && aw_addr == TSS_REG_CTRL) begin
      for (int b = 0; b < 3; b++) begin
        if (w_strb[b]) ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
      end
    end else if (wr_go && aw_addr == TSS_REG_TEMPO && w_strb[1:0] == 2'h3) begin
      // clamp to 10.0 .. 600.0 bpm
      if (w_data[15:0] < 16'(TSS_TEMPO_MIN)) tempo <= TSS_TEMPO_MIN;
      else if (w_data[15:0] > 16'(TSS_TEMPO_MAX)) tempo <= TSS_TEMPO_MAX;
      else tempo <= w_data[12:0];
    end
  end

  wire       in_eighth  = ctrl[TSS_CTRL_IN_SPAN];
  wire       out_eighth = ctrl[TSS_CTRL_OUT_SPAN];
  wire       in_fall    = ctrl[TSS_CTRL_IN_FALL];
  wire       out_fall   = ctrl[TSS_CTRL_OUT_FALL];
  wire [1:0] src_sel    = ctrl[TSS_CTRL_SRC_LO +: 2];
  wire [2:0] res_sel    = ctrl[TSS_CTRL_RES_LO +: 3];
  wire       xport_on   = ctrl[TSS_CTRL_XPORT];
  wire       follow_din_port_tempo = (src_sel == TSS_SRC_FOLLOW_DIN);

  // ===========================================================
  // midi din link domain: toggle per accepted real-time byte
  logic       din_clk_tgl;
  logic       din_xp_tgl;
  logic [1:0] din_xp_code;

  always_ff @(posedge link_clock or posedge link_rst) begin
    if (link_rst) begin
      din_clk_tgl <= 1'b0;
      din_xp_tgl  <= 1'b0;
      din_xp_code <= 2'h0;
    end else if (din_byte_valid) begin
      if (din_byte == TSS_RT_CLOCK) din_clk_tgl <= !din_clk_tgl;
      if (din_byte == TSS_RT_START || din_byte == TSS_RT_CONT || din_byte == TSS_RT_STOP) begin
        din_xp_tgl  <= !din_xp_tgl;
        din_xp_code <= din_byte[1:0];
      end
    end
  end

  // ===========================================================
  // crossings and pulse input synchronisers
  logic [2:0] din_clk_sync;
  logic [3:0] din_xp_sync;
  logic [1:0] din_code_s1;
  logic [1:0] din_code_s2;
  logic [2:0] jack_sync;
  logic [1:0] present_sync;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      din_clk_sync <= 3'h0;
      din_xp_sync  <= 4'h0;
      din_code_s1  <= 2'h0;
      din_code_s2  <= 2'h0;
      jack_sync    <= 3'h0;
      present_sync <= 2'h0;
    end else begin
      din_clk_sync <= {din_clk_sync[1:0], din_clk_tgl};
      din_xp_sync  <= {din_xp_sync[2:0], din_xp_tgl};
      din_code_s1  <= din_xp_code;
      din_code_s2  <= din_code_s1;
      jack_sync    <= {jack_sync[1:0], pulse_in};
      present_sync <= {present_sync[0], pulse_in_present};
    end
  end

  wire din_clk_ev = din_clk_sync[2] ^ din_clk_sync[1];
  wire din_xp_ev  = din_xp_sync[3] ^ din_xp_sync[2]; // late: code settled
  wire jack_rise  = jack_sync[1] && !jack_sync[2];
  wire jack_fall  = !jack_sync[1] && jack_sync[2];
  wire jack_ev    = in_fall ? jack_fall : jack_rise;
  wire jack_on    = present_sync[1];
  wire usb_clk_ev = usb_byte_valid && usb_byte == TSS_RT_CLOCK;
  wire usb_xp_ev  = usb_byte_valid && (usb_byte == TSS_RT_START || usb_byte == TSS_RT_CONT ||
                                       usb_byte == TSS_RT_STOP);

  // ===========================================================
  // external clock presence
  logic [31:0] usb_idle;
  logic [31:0] din_idle;
  wire usb_alive = usb_idle != 32'h0;
  wire din_alive = din_idle != 32'h0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      usb_idle <= 32'h0;
      din_idle <= 32'h0;
    end else begin
      if (usb_clk_ev) usb_idle <= 32'(LOSS_CYCLES);
      else if (usb_alive) usb_idle <= usb_idle - 32'h1;
      if (din_clk_ev) din_idle <= 32'(LOSS_CYCLES);
      else if (din_alive) din_idle <= din_idle - 32'h1;
    end
  end

  // origin choice, jack first
  tss_org_e origin;
  always_comb begin
    if (jack_on) origin = TSS_ORG_JACK;
    else if (src_sel == TSS_SRC_INTERNAL) origin = TSS_ORG_INT;
    else if (follow_din_port_tempo && din_alive) origin = TSS_ORG_DIN;
    else if (src_sel == TSS_SRC_FOLLOW_USB && usb_alive) origin = TSS_ORG_USB;
    else origin = TSS_ORG_INT;
  end

  // ===========================================================
  // internal tempo: phase accumulator of bpm tenths
  logic [31:0] phase;
  wire [31:0] next_phase = phase + {19'h0, tempo};
  wire        int_tick   = next_phase >= TSS_PHASE_FULL;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) phase <= 32'h0;
    else if (int_tick) phase <= next_phase - TSS_PHASE_FULL;
    else phase <= next_phase;
  end

  // midi clock divider to sixteenths
  logic [2:0] midi_div;
  wire midi_ev   = (origin == TSS_ORG_DIN) ? din_clk_ev : usb_clk_ev;
  wire midi_tick = midi_ev && midi_div == TSS_MIDI_PER_16 - 3'h1;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) midi_div <= 3'h0;
    else if (origin == TSS_ORG_INT || origin == TSS_ORG_JACK) midi_div <= 3'h0;
    else if (midi_tick) midi_div <= 3'h0;
    else if (midi_ev) midi_div <= midi_div + 3'h1;
  end

  // sixteenth units gained this cycle
  logic [1:0] gain;
  always_comb begin
    unique case (origin)
      TSS_ORG_JACK: gain = jack_ev ? (in_eighth ? 2'h2 : 2'h1) : 2'h0;
      TSS_ORG_INT:  gain = int_tick ? 2'h1 : 2'h0;
      TSS_ORG_USB,
      TSS_ORG_DIN:  gain = midi_tick ? 2'h1 : 2'h0;
    endcase
  end

  // ===========================================================
  // transport gate
  logic run;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) run <= 1'b0;
    else if (xport_on && usb_xp_ev) run <= usb_byte[1:0] != TSS_RT_STOP[1:0];
    else if (xport_on && din_xp_ev) run <= din_code_s2 != TSS_RT_STOP[1:0];
    else if (wr_go && aw_addr == TSS_REG_CTRL && w_strb[2]) run <= w_data[TSS_CTRL_RUN];
  end

  // ===========================================================
  // step and output pulse counting in sixteenths
  logic [4:0]  sixteenths;
  logic [7:0]  step_pos;
  logic [4:0]  out_acc;
  logic [23:0] pulse_cnt;
  logic [4:0]  step_len;
  always_comb begin
    step_len = 5'h1 << res_sel;
    if (res_sel > TSS_RES_1) step_len = 5'h1;
  end
  wire [5:0] next_six = {1'b0, sixteenths} + {4'h0, gain};
  wire       step_hit = run && next_six >= {1'b0, step_len};
  wire [5:0] next_out = {1'b0, out_acc} + {4'h0, gain};
  wire [5:0] out_need = out_eighth ? 6'h2 : 6'h1;
  wire       out_hit  = run && next_out >= out_need;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sixteenths   <= 5'h0;
      step_pos     <= 8'h0;
      step_advance <= 1'b0;
    end else begin
      step_advance <= step_hit;
      if (!run) sixteenths <= 5'h0;
      else if (step_hit) sixteenths <= 5'(next_six - {1'b0, step_len});
      else sixteenths <= next_six[4:0];
      if (step_hit) step_pos <= step_pos + 8'h1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_acc   <= 5'h0;
      pulse_cnt <= 24'h0;
    end else begin
      if (!run) out_acc <= 5'h0;
      else if (out_hit) out_acc <= 5'(next_out - out_need);
      else out_acc <= next_out[4:0];
      if (out_hit) pulse_cnt <= 24'(PULSE_CYCLES);
      else if (pulse_cnt != 24'h0) pulse_cnt <= pulse_cnt - 24'h1;
    end
  end

  // ===========================================================
  // outputs straight from flops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_out           <= 1'b0;
      seq_running         <= 1'b0;
      link_channel_number <= 4'h0;
    end else begin
      pulse_out           <= out_hit || (pulse_cnt > 24'h1) ? !out_fall : out_fall;
      seq_running         <= run;
      link_channel_number <= ctrl[TSS_CTRL_CHAN_LO +: 4];
    end
  end

  // ===========================================================
  // axi4-lite read channel
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr)
          TSS_REG_CTRL:   s_axi_rdata <= {14'h0, run, ctrl[16:0]};
          TSS_REG_TEMPO:  s_axi_rdata <= {19'h0, tempo};
          TSS_REG_STATUS: s_axi_rdata <= {25'h0, jack_on, din_alive, usb_alive, run,
                                          pulse_out, origin};
          TSS_REG_POS:    s_axi_rdata <= {19'h0, sixteenths, step_pos};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: verification/tss_sync_gear.sv
// far-side gear: din clock sender and pulse jack source
// assumes a free-running link_clock from the bench
`timescale 1ns/1ps
module tss_sync_gear (
  // clocks
  input wire logic  clock,
  input wire logic  link_clock,
  // din link
  output logic       din_byte_valid,
  output logic [7:0] din_byte,
  // jack
  output logic       pulse_in,
  output logic       pulse_in_present
);
  initial begin
    din_byte_valid = 1'h0;
    din_byte = 8'h00;
    pulse_in = 1'h0;
    pulse_in_present = 1'h0;
  end
  // ====
  // real-time bytes carry no channel; idle bus shows inverse
  task send(input logic [7:0] b);
    @(posedge link_clock);
    din_byte_valid <= 1'h1;
    din_byte <= b;
    @(posedge link_clock);
    din_byte_valid <= 1'h0;
    din_byte <= ~b;
    repeat (8) @(posedge link_clock);
  endtask
  // edges six cycles apart
  task toggle(input int n);
    repeat (n) begin
      repeat (6) @(posedge clock);
      pulse_in <= ~pulse_in;
    end
  endtask
  task plug(input logic v);
    @(posedge clock);
    pulse_in_present <= v;
    repeat (4) @(posedge clock);
  endtask
endmodule

// File: verification/tss_tempo_sync_properties.sv
// checker: axi answers, refusals and channel update
// assumes binding onto tss_tempo_sync, one clock domain
`timescale 1ns/1ps
module tss_tempo_sync_properties
  import tss_pkg::*;
#(
  parameter int LOSS_CYCLES  = 200,
  parameter int PULSE_CYCLES = 4
) (
  // system
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [3:0]  link_channel_number,
  // axi
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_t = s_axi_arvalid && s_axi_arready;
  // ====
  // assertions
  a_write_answer: assert property (both |-> ##2 s_axi_bvalid)
    else $error("no write response");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while answering");
  a_read_answer: assert property (ar_t |=> s_axi_rvalid)
    else $error("no read response");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bad_read: assert property (ar_t && s_axi_araddr > TSS_REG_POS |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_bad_write: assert property (both && (s_axi_awaddr > TSS_REG_POS
    || s_axi_awaddr == TSS_REG_STATUS) |-> ##2 s_axi_bresp == 2'h2) else $error("bad write");
  a_chan_written: assert property (both && s_axi_awaddr == TSS_REG_CTRL && s_axi_wstrb[1]
    |-> ##3 link_channel_number == $past(s_axi_wdata[15:12], 3)) else $error("channel");
endmodule
bind tss_tempo_sync tss_tempo_sync_properties
  #(.LOSS_CYCLES(LOSS_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .clock(clock), .sys_rst(sys_rst), .link_channel_number(link_channel_number),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: verification/tss_tempo_sync_bench.sv
// bench: registers, jack pulses, din and usb clock traffic
// assumes dut and gear connect by port name
`timescale 1ns/1ps
module tss_tempo_sync_bench
  import tss_pkg::*;
;
`define CHK(n, s, e) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
  logic        clock = 1'h0;
  logic        sys_rst = 1'h1;
  logic        link_clock = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, usb_byte = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, usb_byte_valid = 1'h0;
  wire         link_rst = sys_rst;
  wire         din_byte_valid, pulse_in, pulse_in_present, pulse_out, step_advance;
  wire         seq_running, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire [7:0]   din_byte;
  wire [3:0]   link_channel_number;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  logic [33:0] eq[$], mq[$];
  logic [1:0]  bq[$];
  logic [16:0] r = 17'h16C88;
  logic [7:0]  pos = 8'h00;
  logic        idle = 1'h0, po_q = 1'h0;
  int          miscompares = 0, checks_done = 0, nouts = 0, nsteps = 0;
  logic [12:0] tw[5] = '{13'h0010, 13'h1FFF, 13'h0064, 13'h1770, 13'h0000};
  logic [12:0] te[5] = '{13'h0064, 13'h1770, 13'h0064, 13'h1770, 13'h0000};
  logic [7:0]  xc[4] = '{TSS_RT_STOP, TSS_RT_START, TSS_RT_STOP, TSS_RT_CONT};
  logic        xe[4] = '{1'h0, 1'h1, 1'h0, 1'h1};
  always #10 clock = ~clock;
  initial begin
    #3;
    forever #6 link_clock = ~link_clock;
  end
  tss_tempo_sync #(.LOSS_CYCLES(200), .PULSE_CYCLES(4)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .link_clock(link_clock), .link_rst(link_rst),
    .din_byte_valid(din_byte_valid), .din_byte(din_byte), .usb_byte_valid(usb_byte_valid),
    .usb_byte(usb_byte), .pulse_in(pulse_in), .pulse_in_present(pulse_in_present),
    .pulse_out(pulse_out), .step_advance(step_advance), .seq_running(seq_running),
    .link_channel_number(link_channel_number), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  tss_sync_gear u_gear (
    .clock(clock), .link_clock(link_clock), .din_byte_valid(din_byte_valid),
    .din_byte(din_byte), .pulse_in(pulse_in), .pulse_in_present(pulse_in_present));
  // ====
  // helpers
  function logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function logic [31:0] cw(input logic [3:0] sp, input logic [1:0] src,
                           input logic [2:0] res, input logic xp);
    return {14'h0, 1'h1, xp, 4'h0, 1'h0, res, 2'h0, src, sp};
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic done;
    bq.push_back(e);
    done = 1'h0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      done = s_axi_bvalid;
      if (done) s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    logic done;
    eq.push_back(e);
    mq.push_back(m);
    done = 1'h0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      done = s_axi_rvalid;
      if (done) s_axi_rready <= 1'h0;
    end
  endtask
  task usb(input logic [7:0] b);
    @(posedge clock);
    usb_byte_valid <= 1'h1;
    usb_byte <= b;
    @(posedge clock);
    usb_byte_valid <= 1'h0;
    usb_byte <= ~b;
    repeat (4) @(posedge clock);
  endtask
  task tog(input int n, input int steps, input int outs);
    int o0;
    int s0;
    o0 = nouts;
    s0 = nsteps;
    pos = pos + 8'(steps);
    u_gear.toggle(n);
    repeat (12) @(posedge clock);
    `CHK("out pulses", nouts - o0, outs);
    `CHK("steps", nsteps - s0, steps);
    rd(TSS_REG_POS, {26'h0, pos}, 34'h1FFF);
  endtask
  task stop_test;
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ====
  // result watcher
  always @(posedge clock) begin
    if (pulse_out !== po_q && pulse_out === ~idle) nouts++;
    if (step_advance === 1'h1) nsteps++;
    po_q <= pulse_out;
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
      `CHK("read word", {s_axi_rresp, s_axi_rdata} & mq[0], eq[0] & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
      `CHK("write resp", s_axi_bresp, bq[0]);
      void'(bq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test;
  end
  // ====
  // sequence
  initial begin
    logic [3:0] c;
    repeat (3) @(posedge clock);
    sys_rst <= 1'h0;
    r = lfsr(r);
    tw[4] = TSS_TEMPO_MIN + {1'h0, r[11:0]};
    te[4] = tw[4];
    rd(TSS_REG_CTRL, {2'h0, TSS_CTRL_RST}, '1);
    rd(TSS_REG_TEMPO, {21'h0, TSS_TEMPO_RST}, '1);
    rd(8'h10, 34'h2_0000_0000, '1);
    wr(8'h10, 32'h0, 2'h2);
    wr(TSS_REG_STATUS, 32'h0, 2'h2);
    foreach (tw[i]) begin
      wr(TSS_REG_TEMPO, {19'h0, tw[i]}, 2'h0);
      rd(TSS_REG_TEMPO, {21'h0, te[i]}, '1);
    end
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : r[3:0];
      wr(TSS_REG_CTRL, {16'h0001, c, 12'h020}, 2'h0);
      @(negedge clock);
      `CHK("channel", link_channel_number, c);
    end
    u_gear.plug(1'h1);
    wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    rd(TSS_REG_STATUS, 34'h3, 34'h3);
    for (int i = 0; i < 5; i++) begin
      wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_INTERNAL, 3'(i), 1'h0), 2'h0);
      tog(32, 16 >> i, 16);
    end
    wr(TSS_REG_CTRL, cw(4'h3, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    tog(8, 8, 4);
    wr(TSS_REG_CTRL, cw(4'h2, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    tog(8, 4, 2);
    wr(TSS_REG_CTRL, cw(4'h4, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    tog(1, 0, 0);
    tog(1, 1, 1);
    idle = 1'h1;
    wr(TSS_REG_CTRL, cw(4'h8, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    repeat (2) @(posedge clock);
    `CHK("pulse idle", pulse_out, 1'h1);
    tog(4, 2, 2);
    idle = 1'h0;
    u_gear.plug(1'h0);
    wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    repeat (12) u_gear.send(TSS_RT_CLOCK);
    rd(TSS_REG_POS, {26'h0, pos}, 34'h1FFF);
    rd(TSS_REG_STATUS, 34'h0, 34'h3);
    wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_FOLLOW_DIN, TSS_RES_16, 1'h0), 2'h0);
    repeat (12) u_gear.send(TSS_RT_CLOCK);
    rd(TSS_REG_STATUS, 34'h2, 34'h3);
    wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_FOLLOW_USB, TSS_RES_16, 1'h0), 2'h0);
    repeat (12) usb(TSS_RT_CLOCK);
    rd(TSS_REG_STATUS, 34'h1, 34'h3);
    wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_INTERNAL, TSS_RES_16, 1'h0), 2'h0);
    usb(TSS_RT_STOP);
    `CHK("running", seq_running, 1'h1);
    wr(TSS_REG_CTRL, cw(4'h0, TSS_SRC_INTERNAL, TSS_RES_16, 1'h1), 2'h0);
    foreach (xc[i]) begin
      if (i[0]) usb(xc[i]);
      else u_gear.send(xc[i]);
      repeat (8) @(posedge clock);
      `CHK("running", seq_running, xe[i]);
    end
    stop_test;
  end
endmodule
